// ==== verilog/quad_pot_serial_command_unit.sv ====
`timescale 1ns/100ps
// Behaviour
// - each wiper register holds 6 bits, decoded to exactly one of 64 taps.
// - load command writes its data into the addressed wiper register.
// - addressed increment adds one to the wiper register, holding at 63.
// - save command copies the wiper register into its stored location.
// - while write protect is low, stored contents change only when reset clears them.
// - restore command loads the wiper register from its stored location.
// - reset command reloads every wiper register from its stored value.
// - power-on and a preset strobe pulse also reload stored wiper values.
// - left-shift command doubles the wiper register.
// - user-store writes the data byte into the addressed spare byte.
// - each frame shifts out the whole word received in the previous frame.
// - shift of zero gives one; shift at or above mid-scale gives 63.
module quad_pot_serial_command_unit
	import quad_pot_pkg::*;
(
	// system clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	// serial link from the host
	input  wire logic                            sclk,
	input  wire logic                            cs_n,
	input  wire logic                            sdi,
	output logic                                 sdo,
	output logic                                 sdo_oe,
	// control pins
	input  wire logic                            preset_strobe_n,
	input  wire logic                            write_protect_n,
	// wiper state
	output logic      [CHANNELS*CODE_W-1:0]      wiper_codes,
	output logic      [CHANNELS*POSITIONS-1:0]   tap_selects,
	output logic                                 read_mode_active
);

	// ---------------- link domain (sclk) ----------------
	logic [BITCNT_W-1:0] bit_cnt_reg;
	logic [WORD_W-1:0]   shift_in_reg;
	logic [WORD_W-1:0]   rx_hold_reg;
	logic                rx_toggle_reg;
	logic [WORD_W-1:0]   shift_in_next;

	assign shift_in_next = {shift_in_reg[WORD_W-2:0], sdi};

	// count clears whenever the host deselects, so a cut-short frame
	// is dropped instead of merging into the next one
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_reg <= '0;
		end else if (bit_cnt_reg != FRAME_BITS) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_in_reg <= WORD_RESET_VAL;
		end else begin
			shift_in_reg <= shift_in_next;
		end
	end

	// the finished word stays put for a whole frame, so the system side
	// may take it after the toggle crosses without a data synchroniser
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_hold_reg   <= WORD_RESET_VAL;
			rx_toggle_reg <= 1'b0;
		end else if (bit_cnt_reg == FRAME_BITS - 5'h01) begin
			rx_hold_reg   <= shift_in_next;
			rx_toggle_reg <= ~rx_toggle_reg;
		end
	end

	// echo of the previous word, msb first; bit 0 is sampled by the host
	// on the same edge that replaces the word
	logic [3:0] tx_index;
	assign tx_index = 4'hf - bit_cnt_reg[3:0];
	assign sdo      = rx_hold_reg[tx_index];
	assign sdo_oe   = ~cs_n;

	// ---------------- system domain (clk) ----------------
	logic [2:0] toggle_sync_reg;
	logic [1:0] preset_sync_reg;
	logic       preset_last_reg;
	logic [1:0] wp_sync_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			toggle_sync_reg <= 3'h0;
			preset_sync_reg <= 2'h3;
			preset_last_reg <= 1'b1;
			wp_sync_reg     <= 2'h0;
		end else begin
			toggle_sync_reg <= {toggle_sync_reg[1:0], rx_toggle_reg};
			preset_sync_reg <= {preset_sync_reg[0], preset_strobe_n};
			preset_last_reg <= preset_sync_reg[1];
			wp_sync_reg     <= {wp_sync_reg[0], write_protect_n};
		end
	end

	// one-cycle pulse per finished word, taken from the synced toggle
	logic word_arrived;
	logic word_valid;
	logic preset_fall;
	logic write_enabled;
	assign word_arrived  = toggle_sync_reg[2] ^ toggle_sync_reg[1];
	assign preset_fall   = preset_last_reg & ~preset_sync_reg[1];
	assign write_enabled = wp_sync_reg[1];

	// the finished word is copied into this domain on the cycle its toggle
	// lands, so all decode below reads flops of its own clock; this costs
	// one cycle of latency, harmless against the spacing between frames
	logic [WORD_W-1:0] cmd_word_reg;
	logic              cmd_valid_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_word_reg  <= WORD_RESET_VAL;
			cmd_valid_reg <= 1'b0;
		end else begin
			cmd_valid_reg <= word_arrived;
			if (word_arrived) begin
				cmd_word_reg <= rx_hold_reg;
			end
		end
	end
	assign word_valid = cmd_valid_reg;

	logic [3:0]        instr;
	logic [3:0]        addr;
	logic [BYTE_W-1:0] data;
	assign instr = cmd_word_reg[INSTR_MSB:INSTR_LSB];
	assign addr  = cmd_word_reg[ADDR_MSB:ADDR_LSB];
	assign data  = cmd_word_reg[DATA_MSB:DATA_LSB];

	// one strobe each for no-operation, restore, save, user store and reset,
	// each true for the single cycle in which the captured word is acted on
	logic cmd_nop;
	logic cmd_restore;
	logic cmd_save;
	logic cmd_user;
	logic cmd_reload;
	assign cmd_nop     = word_valid && instr == INS_NOP;
	assign cmd_restore = word_valid && instr == INS_RESTORE;
	assign cmd_save    = word_valid && instr == INS_SAVE;
	assign cmd_user    = word_valid && instr == INS_USER;
	assign cmd_reload  = word_valid && instr == INS_RESET;

	logic wiper_addr_ok;
	assign wiper_addr_ok = (addr <= ADDR_LAST_WIPER);

	// power-on reload runs one cycle after reset release
	logic power_on_pending_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			power_on_pending_reg <= 1'b1;
		end else begin
			power_on_pending_reg <= 1'b0;
		end
	end

	logic reload_all;
	assign reload_all = power_on_pending_reg | preset_fall
		| cmd_reload;

	// nonvolatile_store: wiper slots 0..3, byte 4 never written, spare bytes 5..15
	logic [BYTE_W-1:0] nonvolatile_store [STORE_DEPTH];
	logic [CODE_W-1:0] wiper_setting_register [CHANNELS];

	// single write port: a save copies the addressed wiper, a user store
	// takes the data byte; protect blocks both at the port, so while it is
	// held low the only other path to the stored values is reset, which clears them
	logic              store_we;
	logic [3:0]        store_wa;
	logic [BYTE_W-1:0] store_wd;
	always_comb begin
		store_we = 1'b0;
		store_wa = addr;
		store_wd = data;
		if (write_enabled) begin
			if (cmd_save && wiper_addr_ok) begin
				store_we = 1'b1;
				store_wd = {2'b00, wiper_setting_register[addr[1:0]]};
			end else if (cmd_user && addr >= ADDR_FIRST_USER) begin
				store_we = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < STORE_DEPTH; i++) begin
				nonvolatile_store[i] <= STORE_RESET_VAL;
			end
		end else if (store_we) begin
			nonvolatile_store[store_wa] <= store_wd;
		end
	end

	function automatic logic [CODE_W-1:0] shl_code(
		input logic [CODE_W-1:0] c);
		logic [CODE_W-1:0] r;
		r = {c[CODE_W-2:0], 1'b0};
		if (c == CODE_ZERO) begin
			r = CODE_ONE;
		end else if (c >= CODE_MID) begin
			r = CODE_FULL;
		end
		return r;
	endfunction : shl_code

	function automatic logic [CODE_W-1:0] inc_code(
		input logic [CODE_W-1:0] c);
		logic [CODE_W-1:0] r;
		r = c;
		if (c != CODE_FULL) begin
			r = c + CODE_ONE;
		end
		return r;
	endfunction : inc_code

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			logic hit;
			assign hit = word_valid && wiper_addr_ok && addr[1:0] == ch;

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					wiper_setting_register[ch] <= CODE_ZERO;
				end else if (reload_all) begin
					wiper_setting_register[ch] <=
						nonvolatile_store[ch][CODE_W-1:0];
				end else if (word_valid) begin
					case (instr)
						INS_LOAD: begin
							if (hit) begin
								wiper_setting_register[ch] <=
									data[CODE_W-1:0];
							end
						end
						INS_RESTORE: begin
							if (hit) begin
								wiper_setting_register[ch] <=
									nonvolatile_store[ch][CODE_W-1:0];
							end
						end
						INS_INC: begin
							if (hit) begin
								wiper_setting_register[ch] <=
									inc_code(wiper_setting_register[ch]);
							end
						end
						INS_INC_ALL: begin
							wiper_setting_register[ch] <=
								inc_code(wiper_setting_register[ch]);
						end
						INS_SHL: begin
							if (hit) begin
								wiper_setting_register[ch] <=
									shl_code(wiper_setting_register[ch]);
							end
						end
						INS_SHL_ALL: begin
							wiper_setting_register[ch] <=
								shl_code(wiper_setting_register[ch]);
						end
						default: begin
						end
					endcase
				end
			end

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					wiper_codes[ch*CODE_W +: CODE_W] <= CODE_ZERO;
				end else begin
					wiper_codes[ch*CODE_W +: CODE_W] <=
						wiper_setting_register[ch];
				end
			end

			wiper_tap_decoder u_dec (
				.clk        (clk),
				.rst_n      (rst_n),
				.code       (wiper_setting_register[ch]),
				.tap_select (tap_selects[ch*POSITIONS +: POSITIONS])
			);
		end
	endgenerate

	// restore leaves the store in read mode until a no-operation arrives
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			read_mode_active <= 1'b0;
		end else if (cmd_restore) begin
			read_mode_active <= 1'b1;
		end else if (cmd_nop) begin
			read_mode_active <= 1'b0;
		end
	end

endmodule : quad_pot_serial_command_unit

// ==== verilog/quad_pot_pkg.sv ====
package quad_pot_pkg;

	localparam int WORD_W       = 16;
	localparam int CODE_W       = 6;
	localparam int POSITIONS    = 64;
	localparam int CHANNELS     = 4;
	localparam int STORE_DEPTH  = 16;
	localparam int BYTE_W       = 8;
	localparam int BITCNT_W     = 5;

	// command word fields
	localparam int INSTR_MSB    = 15;
	localparam int INSTR_LSB    = 12;
	localparam int ADDR_MSB     = 11;
	localparam int ADDR_LSB     = 8;
	localparam int DATA_MSB     = 7;
	localparam int DATA_LSB     = 0;

	// instruction codes
	localparam logic [3:0] INS_NOP       = 4'h0;
	localparam logic [3:0] INS_RESTORE   = 4'h1;
	localparam logic [3:0] INS_SAVE      = 4'h2;
	localparam logic [3:0] INS_USER      = 4'h3;
	localparam logic [3:0] INS_RESET     = 4'h8;
	localparam logic [3:0] INS_LOAD      = 4'hb;
	localparam logic [3:0] INS_SHL       = 4'hc;
	localparam logic [3:0] INS_SHL_ALL   = 4'hd;
	localparam logic [3:0] INS_INC       = 4'he;
	localparam logic [3:0] INS_INC_ALL   = 4'hf;

	// store map
	localparam logic [3:0] ADDR_LAST_WIPER = 4'h3;
	localparam logic [3:0] ADDR_FIRST_USER = 4'h5;

	localparam logic [CODE_W-1:0] CODE_ZERO = 6'h00;
	localparam logic [CODE_W-1:0] CODE_ONE  = 6'h01;
	localparam logic [CODE_W-1:0] CODE_MID  = 6'h20;
	localparam logic [CODE_W-1:0] CODE_FULL = 6'h3f;

	localparam logic [BYTE_W-1:0] STORE_RESET_VAL = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RESET_VAL  = 16'h0000;
	localparam logic [BITCNT_W-1:0] FRAME_BITS    = 5'h10;

endpackage : quad_pot_pkg

// ==== verilog/wiper_tap_decoder.sv ====
`timescale 1ns/100ps
module wiper_tap_decoder
	import quad_pot_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// wiper code in, one switch closed out
	input  wire logic [CODE_W-1:0]    code,
	output logic      [POSITIONS-1:0] tap_select
);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tap_select <= {{(POSITIONS-1){1'b0}}, 1'b1};
		end else begin
			tap_select <= {{(POSITIONS-1){1'b0}}, 1'b1} << code;
		end
	end

endmodule : wiper_tap_decoder

// ==== dv/quad_pot_properties.sv ====
`timescale 1ns/100ps
module quad_pot_properties
	import quad_pot_pkg::*;
(
	// clock and reset
	input wire logic                          clk,
	input wire logic                          rst_n,
	// link and pins
	input wire logic                          sclk,
	input wire logic                          cs_n,
	input wire logic                          sdo,
	input wire logic                          sdo_oe,
	input wire logic                          preset_strobe_n,
	// wiper state
	input wire logic [CHANNELS*CODE_W-1:0]    wiper_codes,
	input wire logic [CHANNELS*POSITIONS-1:0] tap_selects,
	input wire logic                          read_mode_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// cycles since the last link activity or preset; state may only move soon after
	logic [3:0] quiet_reg;
	always_ff @(posedge clk) begin
		if (!rst_n || sclk || !preset_strobe_n)
			quiet_reg <= 4'h0;
		else if (quiet_reg != 4'hf)
			quiet_reg <= quiet_reg + 4'h1;
	end
	oe_follows_cs_a: assert property (sdo_oe == !cs_n)
		else $error("sdo enable does not follow select");
	sdo_idle_stable_a: assert property (cs_n && $past(cs_n) |-> $stable(sdo))
		else $error("sdo moved outside a frame");
	tap0_matches_a: assert property (tap_selects[63:0] == (64'h1 << wiper_codes[5:0]))
		else $error("channel 0 tap does not match code");
	tap3_matches_a: assert property (tap_selects[255:192] == (64'h1 << wiper_codes[23:18]))
		else $error("channel 3 tap does not match code");
	taps_onehot_a: assert property ($countones(tap_selects) == 4)
		else $error("tap selects not one per channel");
	taps_with_code_a: assert property ($changed(tap_selects) |-> $changed(wiper_codes))
		else $error("tap moved without a code change");
	wiper_cause_a: assert property ($changed(wiper_codes) |-> quiet_reg < 4'hc)
		else $error("wiper changed with no command or preset");
	mode_cause_a: assert property ($changed(read_mode_active) |-> quiet_reg < 4'hc)
		else $error("read mode changed with no command");
	cover property ($rose(read_mode_active));
	cover property (wiper_codes[5:0] == CODE_FULL);
	cover property ($fell(preset_strobe_n));
endmodule : quad_pot_properties

bind quad_pot_serial_command_unit quad_pot_properties chk (
	.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdo(sdo),
	.sdo_oe(sdo_oe), .preset_strobe_n(preset_strobe_n),
	.wiper_codes(wiper_codes), .tap_selects(tap_selects),
	.read_mode_active(read_mode_active));

// ==== dv/host_link_model.sv ====
`timescale 1ns/100ps
module host_link_model (
	// link to the device
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// one frame msb first; the link clock stands still outside it
	task automatic xfer(input logic [15:0] w, input int gap, output logic [15:0] r);
		r = 16'h0000;
		cs_n = 1'b0;
		sdi = w[15];
		#(7.5 + gap * 1.1);
		for (int i = 15; i >= 0; i--) begin
			r = {r[14:0], sdo & sdo_oe};
			sclk = 1'b1;
			#7.5;
			sclk = 1'b0;
			if (i > 0) sdi = w[i-1];
			#7.5;
		end
		cs_n = 1'b1;
		sdi = ~sdi;
	endtask : xfer
endmodule : host_link_model

// ==== dv/quad_pot_serial_command_unit_test.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
	error_cnt++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module quad_pot_serial_command_unit_test;
	import quad_pot_pkg::*;
	logic clk, rst_n, preset_strobe_n, write_protect_n;
	logic sclk, cs_n, sdi, sdo, sdo_oe, read_mode_active;
	logic [23:0]  wiper_codes;
	logic [255:0] tap_selects;
	logic [15:0]  last, echo;
	int error_cnt, total_checks, cycles, rm;
	int wip[4];
	int st[16];
	logic [15:0] cmds[] = '{16'hb010, 16'he000, 16'he000, 16'h2000, 16'hb03f,
		16'he000, 16'hb020, 16'hc000, 16'hc000, 16'hb000, 16'hc000, 16'hb105,
		16'hc100, 16'h1000, 16'h0000, 16'h35aa, 16'h3655, 16'hd000, 16'hf000,
		16'h8000, 16'hb2ff, 16'h5000};
	initial clk = 1'b0;
	always #2 clk = ~clk;
	quad_pot_serial_command_unit dut (.clk(clk), .rst_n(rst_n), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
		.preset_strobe_n(preset_strobe_n), .write_protect_n(write_protect_n),
		.wiper_codes(wiper_codes), .tap_selects(tap_selects),
		.read_mode_active(read_mode_active));
	host_link_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe));
	function automatic int shl(int v);
		return v == 0 ? 1 : (v >= 32 ? 63 : 2 * v);
	endfunction : shl
	function automatic int inc(int v);
		return v == 63 ? 63 : v + 1;
	endfunction : inc
	function automatic logic [23:0] pack();
		return {6'(wip[3]), 6'(wip[2]), 6'(wip[1]), 6'(wip[0])};
	endfunction : pack
	task automatic exec(logic [15:0] w);
		int a;
		a = w[11:8];
		case (w[15:12])
		4'h0: rm = 0;
		4'h1: begin
			if (a < 4) wip[a] = st[a] % 64;
			rm = 1;
		end
		4'h2: if (a < 4 && write_protect_n) st[a] = wip[a];
		4'h3: if (a > 4 && write_protect_n) st[a] = w[7:0];
		4'h8: for (int i = 0; i < 4; i++) wip[i] = st[i] % 64;
		4'hb: if (a < 4) wip[a] = w[5:0];
		4'hc: if (a < 4) wip[a] = shl(wip[a]);
		4'hd: for (int i = 0; i < 4; i++) wip[i] = shl(wip[i]);
		4'he: if (a < 4) wip[a] = inc(wip[a]);
		4'hf: for (int i = 0; i < 4; i++) wip[i] = inc(wip[i]);
		default: ;
		endcase
	endtask : exec
	task automatic frame(logic [15:0] w);
		host.xfer(w, $urandom % 3, echo);
		`CHK(echo, last)
		last = w;
		exec(w);
		repeat (10) @(posedge clk);
		`CHK(wiper_codes, pack())
		`CHK(read_mode_active, rm[0])
		for (int i = 0; i < 16; i++)
			`CHK(dut.nonvolatile_store[i], 8'(st[i]))
	endtask : frame
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			error_cnt++;
			wrap_up;
		end
	end
	initial begin
		rst_n = 1'b0;
		preset_strobe_n = 1'b1;
		write_protect_n = 1'b1;
		last = WORD_RESET_VAL;
		void'($urandom(21));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (cmds[i]) frame(cmds[i]);
		$display("test directed done");
		repeat (40) frame({4'($urandom), 4'($urandom), 8'($urandom)});
		$display("test random done");
		@(posedge clk) write_protect_n <= 1'b0;
		frame(16'hb02a);
		frame(16'h2000);
		frame(16'h3733);
		@(posedge clk) write_protect_n <= 1'b1;
		frame(16'h1000);
		frame(16'h0000);
		$display("test protect done");
		frame(16'hb115);
		@(posedge clk) preset_strobe_n <= 1'b0;
		repeat (4) @(posedge clk);
		preset_strobe_n <= 1'b1;
		for (int i = 0; i < 4; i++) wip[i] = st[i] % 64;
		repeat (8) @(posedge clk);
		`CHK(wiper_codes, pack())
		$display("test preset done");
		wrap_up;
	end
endmodule : quad_pot_serial_command_unit_test
